/* rtl/psw_params.svh */
`ifndef PSW_PARAMS_SVH
`define PSW_PARAMS_SVH

// Register map
`define PSW_ADDR_W      4
`define PSW_OFF_WORD    4'h0
`define PSW_RESET       16'h0000
`define PSW_WR_MASK     16'hFC7F
`define PSW_ZERO_WORD   16'h0000

// Field positions
`define PSW_N_BIT       0
`define PSW_C_BIT       1
`define PSW_V_BIT       2
`define PSW_Z_BIT       3
`define PSW_E_BIT       4
`define PSW_MUL_BIT     5
`define PSW_USR_BIT     6
`define PSW_RSV_HI      9
`define PSW_RSV_LO      7
`define PSW_HLD_BIT     10
`define PSW_IEN_BIT     11
`define PSW_LVL_HI      15
`define PSW_LVL_LO      12
`define PSW_ALU_FLAGS   4
`define PSW_MSB         15

`endif

/* rtl/psw_pkg.sv */
`default_nettype none
package psw_pkg;
  // Status word and priority level carriers
  typedef logic [15:0] psw_word_t;
  typedef logic [3:0]  psw_level_t;
  typedef logic [3:0]  psw_addr_t;
  typedef logic [3:0]  psw_alu_flags_t;

  // Bus arbitration states, Gray along off, run, hold
  typedef enum logic [1:0] {
    PSW_ARB_OFF  = 2'b00,
    PSW_ARB_RUN  = 2'b01,
    PSW_ARB_HOLD = 2'b11
  } psw_arb_state_t;
endpackage : psw_pkg
`default_nettype wire

/* rtl/psw_flag_unit.sv */
`timescale 1ns/100ps
`default_nettype none
`include "psw_params.svh"
module psw_flag_unit (
  // ALU outcome
  input  wire logic               alu_result_msb,
  input  wire logic               alu_result_zero,
  input  wire logic               alu_carry,
  input  wire logic               alu_overflow,
  // Flag values in status word order
  output logic [`PSW_ALU_FLAGS-1:0] alu_flags
);
  // Map ALU outcome onto the low status bits
  always_comb begin
    alu_flags                = '0;
    alu_flags[`PSW_N_BIT]    = alu_result_msb;
    alu_flags[`PSW_C_BIT]    = alu_carry;
    alu_flags[`PSW_V_BIT]    = alu_overflow;
    alu_flags[`PSW_Z_BIT]    = alu_result_zero;
  end
endmodule : psw_flag_unit
`default_nettype wire

/* rtl/psw_bus_arbiter.sv */
`timescale 1ns/100ps
`default_nettype none
module psw_bus_arbiter (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,
  // Control
  input  wire logic arb_enable,
  input  wire logic hold_request_in,
  input  wire logic core_bus_idle,
  input  wire logic core_bus_need,
  // Pin drivers
  output logic      bus_hold_acknowledge_out,
  output logic      bus_hold_acknowledge_oe,
  output logic      bus_request_out,
  output logic      bus_request_oe
);
  import psw_pkg::*;

  psw_arb_state_t state;

  // Hold handshake sequencing
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= PSW_ARB_OFF;
    end else begin
      case (state)
        PSW_ARB_OFF: begin
          if (arb_enable) state <= PSW_ARB_RUN;
        end
        PSW_ARB_RUN: begin
          if (!arb_enable) state <= PSW_ARB_OFF;
          else if (hold_request_in && core_bus_idle) state <= PSW_ARB_HOLD;
        end
        PSW_ARB_HOLD: begin
          if (!arb_enable) state <= PSW_ARB_OFF;
          else if (!hold_request_in) state <= PSW_ARB_RUN;
        end
        default: begin
          state <= PSW_ARB_OFF;
        end
      endcase
    end
  end

  // Pin drive, registered; pins released while disabled
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bus_hold_acknowledge_out <= 1'b0;
      bus_hold_acknowledge_oe  <= 1'b0;
      bus_request_out          <= 1'b0;
      bus_request_oe           <= 1'b0;
    end else begin
      bus_hold_acknowledge_oe  <= arb_enable;
      bus_request_oe           <= arb_enable;
      bus_hold_acknowledge_out <= arb_enable && (state == PSW_ARB_HOLD)
                                  && hold_request_in;
      bus_request_out          <= arb_enable && (state == PSW_ARB_HOLD)
                                  && core_bus_need;
    end
  end
endmodule : psw_bus_arbiter
`default_nettype wire

/* rtl/psw_status_word.sv */
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "psw_params.svh"
module psw_status_word (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 sys_rst,
  // Register port
  input  wire psw_pkg::psw_addr_t   reg_addr,
  input  wire psw_pkg::psw_word_t   reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output psw_pkg::psw_word_t        reg_rdata,
  // ALU outcome
  input  wire logic                 alu_valid,
  input  wire psw_pkg::psw_word_t   alu_result,
  input  wire logic                 alu_carry,
  input  wire logic                 alu_overflow,
  // Table search
  input  wire logic                 tbl_valid,
  input  wire logic                 tbl_end,
  // Multiply and divide unit
  input  wire logic                 muldiv_start,
  input  wire logic                 muldiv_done,
  // Interrupt controller
  input  wire logic                 irq_req,
  input  wire psw_pkg::psw_level_t  irq_level,
  input  wire logic                 int_entry,
  input  wire psw_pkg::psw_level_t  int_entry_level,
  output logic                      irq_accept,
  // Bus arbitration
  input  wire logic                 hold_request_in,
  input  wire logic                 core_bus_idle,
  input  wire logic                 core_bus_need,
  output logic                      bus_hold_acknowledge_out,
  output logic                      bus_hold_acknowledge_oe,
  output logic                      bus_request_out,
  output logic                      bus_request_oe,
  // Status word view
  output psw_pkg::psw_word_t        processor_status_word
);
  import psw_pkg::*;

  // Address decode shared by read and write paths
  function automatic logic hit(input psw_addr_t a, input psw_addr_t off);
    hit = (a == off);
  endfunction : hit

  logic                          sw_wr;
  logic                          sw_rd;
  psw_alu_flags_t                alu_flags;
  wire psw_alu_flags_t           flag_reg;
  logic                          end_flag;
  logic                          muldiv_pending_flag;
  logic                          user_flag;
  logic                          bus_arbitration_enable;
  logic                          global_interrupt_enable;
  psw_level_t                    current_priority_level;
  psw_word_t                     next_word;
  psw_word_t                     wr_masked;
  // Reset image of the whole word, sliced per field
  localparam psw_word_t          reset_word = `PSW_RESET;

  // Strobe qualification
  assign sw_wr     = reg_wr && hit(reg_addr, `PSW_OFF_WORD);
  assign sw_rd     = reg_rd && hit(reg_addr, `PSW_OFF_WORD);
  assign wr_masked = reg_wdata & `PSW_WR_MASK;

  // ALU outcome to flag bits
  psw_flag_unit u_flags (
    .alu_result_msb  (alu_result[`PSW_MSB]),
    .alu_result_zero (alu_result == `PSW_ZERO_WORD),
    .alu_carry       (alu_carry),
    .alu_overflow    (alu_overflow),
    .alu_flags       (alu_flags)
  );

  // ALU flags; an ALU update outranks a software write
  // flag update
  genvar gi;
  generate
    for (gi = 0; gi < `PSW_ALU_FLAGS; gi++) begin : g_alu_flag
      logic flag_q;
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          flag_q <= reset_word[gi];
        end else if (alu_valid) begin
          flag_q <= alu_flags[gi];
        end else if (sw_wr) begin
          flag_q <= wr_masked[gi];
        end
      end
      // Each flop drives its own bit of the shared flag net
      assign flag_reg[gi] = flag_q;
    end
  endgenerate

  // End-of-table flag from table search steps
  // table end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      end_flag <= reset_word[`PSW_E_BIT];
    end else if (tbl_valid) begin
      end_flag <= tbl_end;
    end else if (sw_wr) begin
      end_flag <= wr_masked[`PSW_E_BIT];
    end
  end

  // Pending multiply/divide; start outranks completion and writes
  // muldiv pending
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      muldiv_pending_flag <= reset_word[`PSW_MUL_BIT];
    end else if (muldiv_start) begin
      muldiv_pending_flag <= 1'b1;
    end else if (muldiv_done) begin
      muldiv_pending_flag <= 1'b0;
    end else if (sw_wr) begin
      muldiv_pending_flag <= wr_masked[`PSW_MUL_BIT];
    end
  end

  // Software owned general flag
  // user flag
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      user_flag <= reset_word[`PSW_USR_BIT];
    end else if (sw_wr) begin
      user_flag <= wr_masked[`PSW_USR_BIT];
    end
  end

  // Bus arbitration enable
  // arbitration enable
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bus_arbitration_enable <= reset_word[`PSW_HLD_BIT];
    end else if (sw_wr) begin
      bus_arbitration_enable <= wr_masked[`PSW_HLD_BIT];
    end
  end

  // Global interrupt enable
  // interrupt enable
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      global_interrupt_enable <= reset_word[`PSW_IEN_BIT];
    end else if (sw_wr) begin
      global_interrupt_enable <= wr_masked[`PSW_IEN_BIT];
    end
  end

  // Current level; interrupt entry outranks a software write
  // level load
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      current_priority_level <= reset_word[`PSW_LVL_HI:`PSW_LVL_LO];
    end else if (int_entry) begin
      current_priority_level <= int_entry_level;
    end else if (sw_wr) begin
      current_priority_level <= wr_masked[`PSW_LVL_HI:`PSW_LVL_LO];
    end
  end

  // Assemble the status word; unused bits stay zero
  // unused zero
  always_comb begin
    next_word                              = `PSW_ZERO_WORD;
    next_word[`PSW_Z_BIT:`PSW_N_BIT]       = flag_reg;
    next_word[`PSW_E_BIT]                  = end_flag;
    next_word[`PSW_MUL_BIT]                = muldiv_pending_flag;
    next_word[`PSW_USR_BIT]                = user_flag;
    next_word[`PSW_HLD_BIT]                = bus_arbitration_enable;
    next_word[`PSW_IEN_BIT]                = global_interrupt_enable;
    next_word[`PSW_LVL_HI:`PSW_LVL_LO]     = current_priority_level;
  end

  // Registered view of the status word
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      processor_status_word <= `PSW_RESET;
    end else begin
      processor_status_word <= next_word;
    end
  end

  // Read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata <= `PSW_ZERO_WORD;
    end else if (sw_rd) begin
      reg_rdata <= next_word;
    end else begin
      reg_rdata <= `PSW_ZERO_WORD;
    end
  end

  // Interrupt acceptance against the running level
  // acceptance gate
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_accept <= 1'b0;
    end else begin
      irq_accept <= global_interrupt_enable && irq_req && !int_entry
                    && (irq_level > current_priority_level);
    end
  end

  // Hold, acknowledge and request pins
  // pin gating
  psw_bus_arbiter u_arb (
    .mclk                     (mclk),
    .sys_rst                  (sys_rst),
    .arb_enable               (bus_arbitration_enable),
    .hold_request_in          (hold_request_in),
    .core_bus_idle            (core_bus_idle),
    .core_bus_need            (core_bus_need),
    .bus_hold_acknowledge_out (bus_hold_acknowledge_out),
    .bus_hold_acknowledge_oe  (bus_hold_acknowledge_oe),
    .bus_request_out          (bus_request_out),
    .bus_request_oe           (bus_request_oe)
  );

  // Checks on the status word behaviour
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  neg_flag_a: assert property (
    alu_valid |=> flag_reg[`PSW_N_BIT] == $past(alu_result[`PSW_MSB]))
    else $error("negative flag wrong after ALU update");

  carry_flag_a: assert property (
    alu_valid |=> flag_reg[`PSW_C_BIT] == $past(alu_carry))
    else $error("carry flag wrong after ALU update");

  ovf_flag_a: assert property (
    alu_valid ##1 !alu_valid && !sw_wr
      |=> $stable(flag_reg[`PSW_V_BIT])
          && flag_reg[`PSW_V_BIT] == $past(alu_overflow, 2))
    else $error("overflow flag wrong or unstable");

  zero_flag_a: assert property (
    alu_valid |=> flag_reg[`PSW_Z_BIT] ==
      ($past(alu_result) == `PSW_ZERO_WORD))
    else $error("zero flag wrong after ALU update");

  table_end_a: assert property (
    tbl_valid && tbl_end |=> ##1 processor_status_word[`PSW_E_BIT])
    else $error("end flag missing in status view");

  muldiv_set_a: assert property (
    muldiv_start ##1 (!muldiv_done && !sw_wr)[*2]
      |-> muldiv_pending_flag)
    else $error("pending flag dropped during operation");

  muldiv_clr_a: assert property (
    muldiv_done && !muldiv_start |=> !muldiv_pending_flag)
    else $error("pending flag not cleared on completion");

  user_write_a: assert property (
    sw_wr |=> user_flag == $past(reg_wdata[`PSW_USR_BIT]))
    else $error("user flag did not take written value");

  arb_release_a: assert property (
    !bus_arbitration_enable |=> !bus_hold_acknowledge_oe
      && !bus_request_oe && !bus_request_out)
    else $error("arbitration pins driven while disabled");

  irq_block_a: assert property (
    !global_interrupt_enable |=> !irq_accept)
    else $error("interrupt accepted while disabled");

  level_entry_a: assert property (
    int_entry |=> current_priority_level == $past(int_entry_level))
    else $error("level not loaded on interrupt entry");

  level_write_a: assert property (
    sw_wr && !int_entry |=> current_priority_level ==
      $past(reg_wdata[`PSW_LVL_HI:`PSW_LVL_LO]))
    else $error("level not taken from software write");

  unused_zero_a: assert property (
    sw_rd |=> reg_rdata[`PSW_RSV_HI:`PSW_RSV_LO] == 3'h0
      && reg_rdata == $past(next_word))
    else $error("read data wrong or unused bits set");

  ack_release_a: assert property (
    !bus_arbitration_enable |=> !bus_hold_acknowledge_out)
    else $error("hold acknowledge driven while disabled");

  request_need_a: assert property (
    !core_bus_need |=> !bus_request_out)
    else $error("bus request raised without core need");

  hld_write_a: assert property (
    sw_wr |=> bus_arbitration_enable == $past(reg_wdata[`PSW_HLD_BIT]))
    else $error("arbitration enable did not take written value");

  ien_write_a: assert property (
    sw_wr |=> global_interrupt_enable == $past(reg_wdata[`PSW_IEN_BIT]))
    else $error("interrupt enable did not take written value");

  level_mask_a: assert property (
    irq_req && irq_level <= current_priority_level |=> !irq_accept)
    else $error("interrupt accepted at or below running level");

  flag_hold_a: assert property (
    !alu_valid && !sw_wr |=> $stable(flag_reg))
    else $error("ALU flags changed without an update");

  table_hold_a: assert property (
    !tbl_valid && !sw_wr |=> $stable(end_flag))
    else $error("end flag changed without a table step");

  muldiv_hold_a: assert property (
    !muldiv_start && !muldiv_done && !sw_wr
      |=> $stable(muldiv_pending_flag))
    else $error("pending flag changed without a cause");

  user_hold_a: assert property (
    !sw_wr |=> $stable(user_flag))
    else $error("user flag changed without a write");

  stray_write_a: assert property (
    reg_wr && !sw_wr |=> $stable(user_flag)
      && $stable(global_interrupt_enable))
    else $error("write to another address changed the word");

  level_hold_a: assert property (
    !int_entry && !sw_wr |=> $stable(current_priority_level))
    else $error("level changed without entry or write");

  idle_rdata_a: assert property (
    !sw_rd |=> reg_rdata == `PSW_ZERO_WORD)
    else $error("read data not zero outside a read");

  // Main scenarios
  cov_irq_c: cover property (
    int_entry ##1 sw_wr ##1 irq_accept);
  cov_hold_c: cover property (
    bus_arbitration_enable ##[1:4] bus_hold_acknowledge_out);
  cov_muldiv_c: cover property (
    muldiv_start ##[1:8] muldiv_done);
  cov_read_c: cover property (
    alu_valid ##1 sw_rd);
  cov_stray_c: cover property (
    reg_wr && !sw_wr);
endmodule : psw_status_word
`default_nettype wire

/* tb/psw_hold_partner.sv */
`timescale 1ns/100ps
`default_nettype none
module psw_hold_partner #(
  parameter int LAG = 1
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,
  // Bench control
  input  wire logic want_bus,
  output var  logic has_bus,
  // Hold pins
  input  wire logic bus_hold_acknowledge_out,
  input  wire logic bus_hold_acknowledge_oe,
  output var  logic hold_request_in
);
  logic want_q;
  logic ack_line;

  // Undriven acknowledge pin falls to its pull-down level
  assign ack_line = bus_hold_acknowledge_oe & bus_hold_acknowledge_out;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      want_q          <= 1'b0;
      hold_request_in <= 1'b0;
    end else begin
      want_q          <= want_bus;
      hold_request_in <= (LAG > 1) ? want_q : want_bus;
    end
  end

  // Bus is ours only while the acknowledge answers our request
  assign has_bus = hold_request_in & ack_line;
endmodule : psw_hold_partner
`default_nettype wire

/* tb/psw_status_word_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module psw_status_word_tb_top;
  import psw_pkg::*;
  // Stimulus and observed signals
  logic       mclk            = 1'b0;
  logic       sys_rst         = 1'b1;
  psw_addr_t  reg_addr        = 4'h0;
  psw_word_t  reg_wdata       = 16'h0000;
  logic       reg_wr          = 1'b0;
  logic       reg_rd          = 1'b0;
  logic       alu_valid       = 1'b0;
  psw_word_t  alu_result      = 16'h0000;
  logic       alu_carry       = 1'b0;
  logic       alu_overflow    = 1'b0;
  logic       tbl_valid       = 1'b0;
  logic       tbl_end         = 1'b0;
  logic       muldiv_start    = 1'b0;
  logic       muldiv_done     = 1'b0;
  logic       irq_req         = 1'b0;
  psw_level_t irq_level       = 4'h0;
  logic       int_entry       = 1'b0;
  psw_level_t int_entry_level = 4'h0;
  logic       core_bus_idle   = 1'b0;
  logic       core_bus_need   = 1'b0;
  logic       want_bus        = 1'b0;
  psw_word_t  reg_rdata;
  psw_word_t  processor_status_word;
  logic       irq_accept;
  logic       hold_request_in;
  logic       has_bus;
  logic       bus_hold_acknowledge_out;
  logic       bus_hold_acknowledge_oe;
  logic       bus_request_out;
  logic       bus_request_oe;
  int         n_errors        = 0;
  int         checked         = 0;
  psw_word_t  alu_res [4]     = '{16'h8000, 16'h0000, 16'h0001, 16'h7FFF};
  logic [3:0] alu_exp [4]     = '{4'h3, 4'hC, 4'h0, 4'h6};

  // Clock at 40 MHz
  always #12.5 mclk = ~mclk;

  psw_status_word dut (
    .mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .alu_valid, .alu_result, .alu_carry, .alu_overflow, .tbl_valid,
    .tbl_end, .muldiv_start, .muldiv_done, .irq_req, .irq_level,
    .int_entry, .int_entry_level, .irq_accept, .hold_request_in,
    .core_bus_idle, .core_bus_need, .bus_hold_acknowledge_out,
    .bus_hold_acknowledge_oe, .bus_request_out, .bus_request_oe,
    .processor_status_word
  );

  psw_hold_partner #(.LAG(2)) partner (
    .mclk, .sys_rst, .want_bus, .has_bus, .bus_hold_acknowledge_out,
    .bus_hold_acknowledge_oe, .hold_request_in
  );

  // Compare and count
  task chk(input psw_word_t seen, input psw_word_t exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One-cycle write strobe, then one quiet cycle
  task wr(input psw_addr_t a, input psw_word_t d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    @(posedge mclk);
  endtask : wr

  // Read data is looked at only in the cycle after the strobe
  task rd(input psw_addr_t a, input psw_word_t exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 chk(reg_rdata, exp);
    @(posedge mclk);
  endtask : rd

  task pins(input psw_word_t exp);
    #1 chk(16'({bus_request_oe, bus_hold_acknowledge_oe,
                bus_hold_acknowledge_out, bus_request_out, has_bus}), exp);
    @(posedge mclk);
  endtask : pins

  task finish_test;
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge mclk);
    n_errors++;
    finish_test;
  end

  // Test sequence
  initial begin
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    rd(4'h0, 16'h0000);
    wr(4'h0, 16'hFFFF);
    rd(4'h0, 16'hFC7F);
    #1 chk(processor_status_word, 16'hFC7F);
    @(posedge mclk);
    rd(4'h3, 16'h0000);
    wr(4'h5, 16'h0000);
    rd(4'h0, 16'hFC7F);
    wr(4'h0, 16'h0040);
    rd(4'h0, 16'h0040);
    // ALU outcomes with the user flag left standing
    for (int i = 0; i < 4; i++) begin
      alu_valid    <= 1'b1;
      alu_result   <= alu_res[i];
      alu_carry    <= alu_exp[i][1];
      alu_overflow <= alu_exp[i][2];
      @(posedge mclk);
      alu_valid    <= 1'b0;
      @(posedge mclk);
      rd(4'h0, {12'h004, alu_exp[i]});
    end
    // End of table set, then cleared
    for (int j = 1; j >= 0; j--) begin
      tbl_valid <= 1'b1;
      tbl_end   <= j[0];
      @(posedge mclk);
      tbl_valid <= 1'b0;
      @(posedge mclk);
      rd(4'h0, {9'h000, 1'b1, 1'b0, j[0], 4'h6});
    end
    // Start beats done in the same cycle
    muldiv_start <= 1'b1;
    muldiv_done  <= 1'b1;
    @(posedge mclk);
    muldiv_start <= 1'b0;
    muldiv_done  <= 1'b0;
    @(posedge mclk);
    rd(4'h0, 16'h0066);
    muldiv_start <= 1'b1;
    @(posedge mclk);
    muldiv_start <= 1'b0;
    @(posedge mclk);
    rd(4'h0, 16'h0066);
    muldiv_done <= 1'b1;
    @(posedge mclk);
    muldiv_done <= 1'b0;
    @(posedge mclk);
    rd(4'h0, 16'h0046);
    // Interrupt gate and current level
    irq_req   <= 1'b1;
    irq_level <= 4'h5;
    repeat (3) @(posedge mclk);
    #1 chk(16'(irq_accept), 16'h0000);
    @(posedge mclk);
    wr(4'h0, 16'h0800);
    #1 chk(16'(irq_accept), 16'h0001);
    @(posedge mclk);
    int_entry       <= 1'b1;
    int_entry_level <= 4'h7;
    @(posedge mclk);
    int_entry       <= 1'b0;
    @(posedge mclk);
    rd(4'h0, 16'h7800);
    #1 chk(16'(irq_accept), 16'h0000);
    @(posedge mclk);
    wr(4'h0, 16'h3800);
    #1 chk(16'(irq_accept), 16'h0001);
    @(posedge mclk);
    rd(4'h0, 16'h3800);
    wr(4'h0, 16'h0000);
    #1 chk(16'(irq_accept), 16'h0000);
    @(posedge mclk);
    irq_req <= 1'b0;
    // Hold pins off while disabled, then granted
    core_bus_idle <= 1'b1;
    want_bus      <= 1'b1;
    repeat (5) @(posedge mclk);
    pins(16'h0000);
    wr(4'h0, 16'h0400);
    repeat (5) @(posedge mclk);
    pins(16'h001D);
    core_bus_need <= 1'b1;
    repeat (3) @(posedge mclk);
    pins(16'h001F);
    wr(4'h0, 16'h0000);
    @(posedge mclk);
    pins(16'h0000);
    finish_test;
  end
endmodule : psw_status_word_tb_top
`default_nettype wire
